// ---- testbench.sv ----
// Purpose: Self-checking bench for the vectored interrupt prioritizer
// Assumes: Default identity source map; table entry e holds 0x10000 + 4*e
// Notes:   Inputs change on the falling edge; a CPU model answers dispatches

module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************************************
	// Signals
	// ****************************************************************
	logic               clock, rst_b, map_wr_en, vec_wr_en, cpu_ack, ack_on;
	logic [127:0]       src_req, chan_enable;   // Request and enable lines
	vip_pkg::vip_disp_t dispatch_mode;          // Dispatch style
	logic [6:0]         map_wr_chan, map_wr_src, vec_wr_entry, parity_err_entry;
	logic [31:0]        vec_wr_data, cpu_vec_addr, sw_vector, took_vec;
	logic               cpu_irq, cpu_vec_valid, parity_err, par_seen;
	logic [7:0]         sw_index, took_idx;
	logic [3:0]         ack_wait;               // CPU model latency
	logic [15:0]        ack_cnt;
	int                 miscompares, checks;

	always #5 clock = ~clock;

	vip_manager i_vip_manager (.clock(clock), .rst_b(rst_b), .src_req(src_req),
		.chan_enable(chan_enable), .dispatch_mode(dispatch_mode), .map_wr_en(map_wr_en),
		.map_wr_chan(map_wr_chan), .map_wr_src(map_wr_src), .vec_wr_en(vec_wr_en),
		.vec_wr_entry(vec_wr_entry), .vec_wr_data(vec_wr_data), .cpu_ack(cpu_ack),
		.cpu_irq(cpu_irq), .cpu_vec_valid(cpu_vec_valid), .cpu_vec_addr(cpu_vec_addr),
		.sw_index(sw_index), .sw_vector(sw_vector), .parity_err(parity_err),
		.parity_err_entry(parity_err_entry));

	vip_cpu_model i_vip_cpu_model (.clock(clock), .rst_b(rst_b), .ack_on(ack_on),
		.ack_wait(ack_wait), .cpu_irq(cpu_irq), .cpu_vec_addr(cpu_vec_addr),
		.sw_vector(sw_vector), .sw_index(sw_index), .cpu_ack(cpu_ack),
		.took_vec(took_vec), .took_idx(took_idx), .ack_cnt(ack_cnt));

	// Any parity pulse is remembered until the closing check
	always @(posedge clock) begin
		if (rst_b !== 1'b1) begin
			par_seen <= 1'b0;
		end else if (parity_err === 1'b1) begin
			par_seen <= 1'b1;
		end
	end

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [31:0] vec_of(input int e);
		return 32'h0001_0000 + 32'(e) * 32'h4;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	// Wait for a dispatch, check the outputs of the mode, then the ack
	task automatic take(input int e, input vip_pkg::vip_disp_t m, input bit hold);
		logic [15:0] n0;
		int          k;
		n0 = ack_cnt;
		k = 0;
		while (cpu_irq !== 1'b1 && k < 20) begin
			@(negedge clock);
			k++;
		end
		if (hold) begin
			repeat (4) @(negedge clock); // A slow CPU must still see it
		end
		chk(32'(cpu_irq), 32'h1);
		chk(32'(cpu_vec_valid), 32'(m == vip_pkg::DISP_HW));
		chk(cpu_vec_addr, (m == vip_pkg::DISP_HW) ? vec_of(e) : 32'h0);
		chk(32'(sw_index), (m == vip_pkg::DISP_INDEX) ? 32'(e) : 32'h0);
		chk(sw_vector, (m == vip_pkg::DISP_REGVEC) ? vec_of(e) : 32'h0);
		k = 0;
		while (ack_cnt === n0 && k < 20) begin
			@(negedge clock);
			k++;
		end
		chk(32'(ack_cnt - n0), 32'h1);
		chk(32'(cpu_irq), 32'h0);
		chk(32'(took_idx), (m == vip_pkg::DISP_INDEX) ? 32'(e) : 32'h0);
		chk(took_vec, (m == vip_pkg::DISP_INDEX) ? 32'h0 : vec_of(e));
	endtask

	// Raise one source on one channel, expect it, then release it
	task automatic run_one(input int ch, input int src, input vip_pkg::vip_disp_t m,
		input bit hold);
		dispatch_mode = m;
		src_req[src] = 1'b1;
		chan_enable[ch] = 1'b1;
		take(ch + 1, m, hold);
		src_req[src] = 1'b0;
		chan_enable[ch] = 1'b0;
		repeat (3) @(negedge clock);
	endtask

	// No dispatch may appear for a while
	task automatic quiet();
		logic seen;
		seen = 1'b0;
		repeat (12) begin
			@(negedge clock);
			seen = seen | (cpu_irq !== 1'b0);
		end
		chk(32'(seen), 32'h0);
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_default_map();
		int tab[13];
		tab = '{vip_pkg::CH_ERR_LO, vip_pkg::CH_TICK_CMP3, vip_pkg::CH_TICK_BASE,
			vip_pkg::CH_HETA_L1, vip_pkg::CH_BSPA_L1, vip_pkg::CH_CVA_MAG,
			vip_pkg::CH_CANA_IF3, vip_pkg::CH_CVB_MAG, vip_pkg::CH_CANC_IF3,
			vip_pkg::CH_BSPE_L1, vip_pkg::CH_PSPD_L0, vip_pkg::CH_HETB_L1, vip_pkg::CH_I2C_L0};
		// Every style is used in turn while the channels walk the map
		for (int i = 0; i < 13; i++) begin
			run_one(tab[i], tab[i], vip_pkg::vip_disp_t'(i % 3), 1'b0);
		end
		$display("test default_map done");
	endtask

	task automatic t_priority();
		dispatch_mode = vip_pkg::DISP_HW;
		src_req[20] = 1'b1;
		src_req[0] = 1'b1;
		chan_enable[20] = 1'b1;
		chan_enable[0] = 1'b1;
		take(1, vip_pkg::DISP_HW, 1'b0);
		take(21, vip_pkg::DISP_HW, 1'b0);
		src_req[20] = 1'b0;
		src_req[0] = 1'b0;
		chan_enable[20] = 1'b0;
		chan_enable[0] = 1'b0;
		repeat (3) @(negedge clock);
		$display("test priority done");
	endtask

	// A lower channel arriving while a slow CPU waits takes the port over
	task automatic t_preempt();
		dispatch_mode = vip_pkg::DISP_HW;
		ack_wait = 4'h6;
		src_req[20] = 1'b1;
		chan_enable[20] = 1'b1;
		repeat (4) @(negedge clock);
		chk(cpu_vec_addr, vec_of(21));
		src_req[0] = 1'b1;
		chan_enable[0] = 1'b1;
		@(negedge clock);
		chk(32'(cpu_irq), 32'h0);
		ack_wait = 4'h0;
		take(1, vip_pkg::DISP_HW, 1'b0);
		take(21, vip_pkg::DISP_HW, 1'b0);
		{src_req[0], src_req[20], chan_enable[0], chan_enable[20]} = 4'h0;
		repeat (3) @(negedge clock);
		$display("test preempt done");
	endtask

	task automatic t_refused();
		src_req[9] = 1'b1;
		quiet();
		src_req[9] = 1'b0;
		src_req[1] = 1'b1;
		chan_enable[1] = 1'b1;
		quiet();
		src_req[1] = 1'b0;
		// Give the top channel a live source so only its missing slot blocks it
		map_wr_en = 1'b1;
		map_wr_chan = 7'h7f;
		map_wr_src = 7'h7f;
		@(negedge clock);
		map_wr_en = 1'b0;
		src_req[127] = 1'b1;
		chan_enable[127] = 1'b1;
		quiet();
		src_req[127] = 1'b0;
		chan_enable[127] = 1'b0;
		$display("test refused done");
	endtask

	task automatic t_remap_slow();
		map_wr_en = 1'b1;
		map_wr_chan = 7'h01;
		map_wr_src = 7'h09;
		@(negedge clock);
		map_wr_en = 1'b0;
		ack_wait = 4'h6;
		run_one(1, 9, vip_pkg::DISP_REGVEC, 1'b1);
		chk(took_vec, vec_of(2));
		ack_wait = 4'h0;
		$display("test remap_slow done");
	endtask

	task automatic final_report();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ****************************************************************
	// Main sequence and watchdog
	// ****************************************************************
	initial begin
		{clock, map_wr_en, vec_wr_en} = 3'h0;
		{src_req, chan_enable} = 256'h0;
		{map_wr_chan, map_wr_src, vec_wr_entry} = 21'h0;
		{vec_wr_data, ack_wait, ack_on} = 37'h1;
		dispatch_mode = vip_pkg::DISP_HW;
		miscompares = 0;
		checks = 0;
		rst_b = 1'b0;
		repeat (4) @(posedge clock);
		@(negedge clock);
		chk(32'({cpu_irq, cpu_vec_valid, parity_err, parity_err_entry, sw_index}), 32'h0);
		chk(cpu_vec_addr | sw_vector, 32'h0);
		rst_b = 1'b1;
		// The table has no reset, so every entry is loaded first
		for (int e = 0; e < 128; e++) begin
			vec_wr_en = 1'b1;
			vec_wr_entry = 7'(e);
			vec_wr_data = vec_of(e);
			@(negedge clock);
		end
		vec_wr_en = 1'b0;
		t_default_map();
		t_priority();
		t_preempt();
		t_refused();
		t_remap_slow();
		chk(32'({par_seen, parity_err_entry}), 32'h0);
		final_report();
	end

	initial begin
		#100000;
		miscompares++;
		final_report();
	end
endmodule

// ---- vip_cpu_model.sv ----
// Purpose: CPU side of the interrupt and vector port; acknowledges dispatches
// Assumes: Same clock as the manager; ack is sampled on the rising edge
// Notes:   Ack delay is set by the bench so prompt and slow CPUs both appear

// ****************************************************************
// CPU model
// ****************************************************************
module vip_cpu_model (
	input  wire logic        clock,         // System clock
	input  wire logic        rst_b,         // Reset, active low
	input  wire logic        ack_on,        // Acknowledge allowed
	input  wire logic [3:0]  ack_wait,      // Cycles irq stands before ack
	input  wire logic        cpu_irq,       // Dispatch presented
	input  wire logic [31:0] cpu_vec_addr,  // Hardware vector
	input  wire logic [31:0] sw_vector,     // Register vector
	input  wire logic [7:0]  sw_index,      // Channel index
	output logic             cpu_ack,       // Vector or index taken
	output logic [31:0]      took_vec,      // Vector seen at the ack
	output logic [7:0]       took_idx,      // Index seen at the ack
	output logic [15:0]      ack_cnt        // Acks taken so far
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [3:0] wait_cnt; // Cycles the dispatch has stood

	// Capture what the CPU reads at the edge the ack is taken
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wait_cnt <= 4'h0;
			ack_cnt  <= 16'h0;
			took_vec <= 32'h0;
			took_idx <= 8'h0;
		end else if (cpu_irq && cpu_ack) begin
			took_vec <= cpu_vec_addr | sw_vector; // Only one is live per mode
			took_idx <= sw_index;
			ack_cnt  <= ack_cnt + 16'h1;
			wait_cnt <= 4'h0;
		end else if (cpu_irq) begin
			wait_cnt <= wait_cnt + 4'h1;
		end else begin
			wait_cnt <= 4'h0;
		end
	end

	// Ack rises after a falling edge and is a single pulse per dispatch,
	// so a slow CPU never takes the same dispatch twice
	always @(negedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cpu_ack <= 1'b0;
		end else begin
			cpu_ack <= ack_on && cpu_irq && (wait_cnt >= ack_wait) && !cpu_ack;
		end
	end
endmodule

// ---- vip_manager.sv ----
// Purpose: Vectored interrupt manager: map, enable, prioritise, dispatch
// Assumes: Request lines and configuration come from logic on the same clock
// Notes:   Lower channel number always wins; one request in flight at a time

// ****************************************************************
// Top module
// ****************************************************************
module vip_manager (
	input  wire logic                clock,            // System clock
	input  wire logic                rst_b,            // Asynchronous reset
	input  wire logic [127:0]        src_req,          // Peripheral request levels
	input  wire logic [127:0]        chan_enable,      // Per-channel enable
	input  wire vip_pkg::vip_disp_t  dispatch_mode,    // Dispatch style
	input  wire logic                map_wr_en,        // Channel map write strobe
	input  wire logic [6:0]          map_wr_chan,      // Channel being remapped
	input  wire logic [6:0]          map_wr_src,       // Source for that channel
	input  wire logic                vec_wr_en,        // Vector table write strobe
	input  wire logic [6:0]          vec_wr_entry,     // Table entry
	input  wire logic [31:0]         vec_wr_data,      // Routine address
	input  wire logic                cpu_ack,          // Vector or index taken
	output logic                     cpu_irq,          // Interrupt to the CPU
	output logic                     cpu_vec_valid,    // Vector port valid
	output logic [31:0]              cpu_vec_addr,     // Vector port address
	output logic [7:0]               sw_index,         // Channel plus one in index mode, else 0
	output logic [31:0]              sw_vector,        // Vector register
	output logic                     parity_err,       // One-cycle parity fault
	output logic [6:0]               parity_err_entry  // Entry that failed
);

	// ****************************************************************
	// Types and helpers
	// ****************************************************************

	// Dispatch sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,   // Waiting for a pending channel
		ST_FETCH,  // Table address on the memory
		ST_CHECK,  // Table word back, parity checked
		ST_SHOW    // Interrupt held until acknowledged
	} vip_state_t;

	// Default live channels after reset
	function automatic logic default_live(input int ch);
		logic hit;
		hit = 1'b0;
		hit |= (ch == vip_pkg::CH_ERR_HI) || (ch == vip_pkg::CH_ERR_LO);
		hit |= (ch >= vip_pkg::CH_TICK_CMP0) && (ch <= vip_pkg::CH_TICK_CMP3);
		hit |= (ch == vip_pkg::CH_TICK_OVF0) || (ch == vip_pkg::CH_TICK_OVF1)
			|| (ch == vip_pkg::CH_TICK_BASE);
		hit |= (ch == vip_pkg::CH_HETA_L0) || (ch == vip_pkg::CH_HETA_L1)
			|| (ch == vip_pkg::CH_TUA_L0) || (ch == vip_pkg::CH_TUA_L1);
		hit |= (ch == vip_pkg::CH_BSPA_L0) || (ch == vip_pkg::CH_BSPA_L1)
			|| (ch == vip_pkg::CH_LIN_L0) || (ch == vip_pkg::CH_LIN_L1);
		hit |= (ch == vip_pkg::CH_CVA_EVT) || (ch == vip_pkg::CH_CVA_G1)
			|| (ch == vip_pkg::CH_CVA_G2) || (ch == vip_pkg::CH_CVA_MAG);
		hit |= (ch == vip_pkg::CH_CANA_L0) || (ch == vip_pkg::CH_CANA_L1)
			|| (ch == vip_pkg::CH_CANA_IF3);
		hit |= (ch == vip_pkg::CH_CVB_EVT) || (ch == vip_pkg::CH_CVB_G1)
			|| (ch == vip_pkg::CH_CVB_G2) || (ch == vip_pkg::CH_CVB_MAG);
		hit |= (ch == vip_pkg::CH_CANB_L0) || (ch == vip_pkg::CH_CANB_L1)
			|| (ch == vip_pkg::CH_CANB_IF3) || (ch == vip_pkg::CH_CANC_L0)
			|| (ch == vip_pkg::CH_CANC_L1) || (ch == vip_pkg::CH_CANC_IF3);
		hit |= (ch == vip_pkg::CH_BSPC_L0) || (ch == vip_pkg::CH_BSPC_L1)
			|| (ch == vip_pkg::CH_BSPE_L0) || (ch == vip_pkg::CH_BSPE_L1);
		hit |= (ch == vip_pkg::CH_PSPB_L0) || (ch == vip_pkg::CH_PSPB_L1)
			|| (ch == vip_pkg::CH_PSPD_L0) || (ch == vip_pkg::CH_PSPD_L1);
		hit |= (ch == vip_pkg::CH_HETB_L0) || (ch == vip_pkg::CH_HETB_L1)
			|| (ch == vip_pkg::CH_TUB_L0) || (ch == vip_pkg::CH_TUB_L1);
		hit |= (ch == vip_pkg::CH_ASU_L0) || (ch == vip_pkg::CH_ASU_L1)
			|| (ch == vip_pkg::CH_I2C_L0);
		hit |= vip_pkg::OTHER_LIVE[ch];
		return hit;
	endfunction

	// Lowest set bit; lower number means higher priority
	function automatic logic [6:0] lowest_set(input logic [127:0] v);
		logic [6:0] idx;
		idx = 7'h00;
		for (int i = vip_pkg::NUM_CHAN - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = 7'(i);
			end
		end
		return idx;
	endfunction

	// ****************************************************************
	// Channel map
	// ****************************************************************

	logic [6:0]   map_src_reg [0:127];  // Source driving each channel
	logic [6:0]   map_src_next [0:127]; // Next source selection
	logic [127:0] map_live_reg;         // Channel has a source attached
	logic [127:0] map_live_next;        // Next live flags

	// Remap write replaces the default routing of one channel
	always_comb begin
		map_src_next  = map_src_reg;
		map_live_next = map_live_reg;
		if (map_wr_en) begin
			map_src_next[map_wr_chan]  = map_wr_src;
			map_live_next[map_wr_chan] = 1'b1;
		end
	end

	// Reset loads the default map; reserved channels start dead
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < vip_pkg::NUM_CHAN; i++) begin
				map_src_reg[i]  <= 7'(i);
				map_live_reg[i] <= default_live(i);
			end
		end else begin
			map_src_reg  <= map_src_next;
			map_live_reg <= map_live_next;
		end
	end

	// ****************************************************************
	// Pending requests
	// ****************************************************************

	logic [127:0] req_mapped;  // Request seen on each channel
	logic [127:0] pending;     // Enabled, not yet taken
	logic [127:0] serv_reg;    // Taken, waiting for source to drop
	logic [127:0] serv_next;   // Next taken flags
	logic         any_pend;    // Some channel is pending
	logic [6:0]   win_chan;    // Winning channel

	vip_state_t  state_reg,    state_next;     // Sequencer state
	logic [6:0]  cur_chan_reg, cur_chan_next;  // Channel being dispatched
	logic        phantom_reg,  phantom_next;   // Fetching phantom entry
	logic        irq_reg,      irq_next;       // Interrupt line
	logic        vvalid_reg,   vvalid_next;    // Vector port valid
	logic [31:0] vaddr_reg,    vaddr_next;     // Vector port address
	logic [7:0]  index_reg,    index_next;     // Software index
	logic [31:0] swvec_reg,    swvec_next;     // Software vector
	logic        perr_reg,     perr_next;      // Parity fault pulse
	logic [6:0]  pent_reg,     pent_next;      // Failing entry
	logic [6:0]  rd_entry;                     // Table read entry
	logic [32:0] rd_word;                      // Table read data
	logic        rd_bad;                       // Read word fails parity

	// Route each channel from its source; top channel has no table slot
	always_comb begin
		for (int i = 0; i < vip_pkg::NUM_CHAN; i++) begin
			req_mapped[i] = map_live_reg[i] && src_req[map_src_reg[i]];
		end
		req_mapped[vip_pkg::LAST_CHAN] = 1'b0;
		pending  = req_mapped & chan_enable & ~serv_reg;
		any_pend = |pending;
		win_chan = lowest_set(pending);
	end

	// Level requests would re-fire right after an ack, so a taken channel
	// is held off until its source lets go; an ack in that cycle still sets
	always_comb begin
		serv_next = serv_reg & req_mapped;
		if (state_reg == ST_SHOW && cpu_ack) begin
			serv_next[cur_chan_reg] = 1'b1;
		end
	end

	// Taken flags
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			serv_reg <= 128'h0;
		end else begin
			serv_reg <= serv_next;
		end
	end

	// ****************************************************************
	// Dispatch sequencer
	// ****************************************************************

	// Channel n lives one entry above its number; entry 0 is the phantom
	always_comb begin
		rd_entry = phantom_reg ? vip_pkg::PHANTOM_ENT : cur_chan_reg + 7'h01;
		rd_bad   = vip_pkg::vec_parity(rd_word[31:0]) != rd_word[vip_pkg::PAR_BIT];
	end

	// Next state and output values
	always_comb begin
		state_next    = state_reg;
		cur_chan_next = cur_chan_reg;
		phantom_next  = phantom_reg;
		irq_next      = irq_reg;
		vvalid_next   = vvalid_reg;
		vaddr_next    = vaddr_reg;
		index_next    = index_reg;
		swvec_next    = swvec_reg;
		perr_next     = 1'b0;
		pent_next     = pent_reg;
		unique case (state_reg)
			// Pick the best pending channel
			ST_IDLE: begin
				if (any_pend) begin
					cur_chan_next = win_chan;
					phantom_next  = 1'b0;
					state_next    = ST_FETCH;
				end
			end
			// Address is on the table this cycle
			ST_FETCH: begin
				state_next = ST_CHECK;
			end
			// A corrupt channel vector is not handed out: fall back to the phantom, which is shown even if corrupt
			ST_CHECK: begin
				if (rd_bad && !phantom_reg) begin
					perr_next    = 1'b1;
					pent_next    = rd_entry;
					phantom_next = 1'b1;
					state_next   = ST_FETCH;
				end else begin
					irq_next   = 1'b1;
					state_next = ST_SHOW;
					unique case (dispatch_mode)
						vip_pkg::DISP_HW: begin
							vvalid_next = 1'b1;
							vaddr_next  = rd_word[31:0];
						end
						vip_pkg::DISP_INDEX: begin
							index_next = {1'b0, cur_chan_reg} + 8'h01;
						end
						vip_pkg::DISP_REGVEC: begin
							swvec_next = rd_word[31:0];
						end
						default: vvalid_next = 1'b0; // Illegal code raises irq with no vector or index
					endcase
				end
			end
			// Hold until taken; drop if withdrawn or beaten
			ST_SHOW: begin
				if (cpu_ack || !pending[cur_chan_reg] || win_chan < cur_chan_reg) begin
					irq_next    = 1'b0;
					vvalid_next = 1'b0;
					vaddr_next  = vip_pkg::VEC_RST;
					index_next  = 8'h00;
					swvec_next  = vip_pkg::VEC_RST;
					state_next  = ST_IDLE;
				end
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_reg    <= ST_IDLE;
			cur_chan_reg <= 7'h00;
			phantom_reg  <= 1'b0;
			irq_reg      <= 1'b0;
			vvalid_reg   <= 1'b0;
			vaddr_reg    <= vip_pkg::VEC_RST;
			index_reg    <= 8'h00;
			swvec_reg    <= vip_pkg::VEC_RST;
			perr_reg     <= 1'b0;
			pent_reg     <= 7'h00;
		end else begin
			state_reg    <= state_next;
			cur_chan_reg <= cur_chan_next;
			phantom_reg  <= phantom_next;
			irq_reg      <= irq_next;
			vvalid_reg   <= vvalid_next;
			vaddr_reg    <= vaddr_next;
			index_reg    <= index_next;
			swvec_reg    <= swvec_next;
			perr_reg     <= perr_next;
			pent_reg     <= pent_next;
		end
	end

	// ****************************************************************
	// Vector table
	// ****************************************************************

	// Parity is generated on the way in and checked on the way out
	vip_vector_ram u_table (
		.clock   (clock),
		.rst_b   (rst_b),
		.wr_en   (vec_wr_en),
		.wr_addr (vec_wr_entry),
		.wr_data ({vip_pkg::vec_parity(vec_wr_data), vec_wr_data}),
		.rd_addr (rd_entry),
		.rd_data (rd_word)
	);

	// Outputs
	assign cpu_irq          = irq_reg;
	assign cpu_vec_valid    = vvalid_reg;
	assign cpu_vec_addr     = vaddr_reg;
	assign sw_index         = index_reg;
	assign sw_vector        = swvec_reg;
	assign parity_err       = perr_reg;
	assign parity_err_entry = pent_reg;

	// ****************************************************************
	// Assertions
	// ****************************************************************

	// Dispatch start: pick, fetch, check
	sequence seq_start;
		state_reg == ST_IDLE && any_pend ##1 state_reg == ST_FETCH ##1 state_reg == ST_CHECK;
	endsequence

	// Show or retry after the check
	property prop_after_check;
		@(posedge clock) disable iff (!rst_b)
		seq_start |=> (state_reg == ST_SHOW || state_reg == ST_FETCH);
	endproperty

	AST_DISPATCH_STEPS: assert property (prop_after_check)
		else $error("dispatch did not reach show or retry");
	AST_WIN_LOWEST: assert property (@(posedge clock) disable iff (!rst_b)
		state_reg == ST_IDLE && any_pend |=> cur_chan_reg == $past(win_chan))
		else $error("dispatched channel is not the lowest pending");
	AST_DISABLED_DROPS: assert property (@(posedge clock) disable iff (!rst_b)
		state_reg == ST_SHOW && !chan_enable[cur_chan_reg] |=> !irq_reg)
		else $error("disabled channel still forwarded");
	AST_INDEX_OFFSET: assert property (@(posedge clock) disable iff (!rst_b)
		index_reg != 8'h00 |-> index_reg == {1'b0, cur_chan_reg} + 8'h01 && irq_reg)
		else $error("software index not channel plus one");
	AST_HW_VECTOR: assert property (@(posedge clock) disable iff (!rst_b)
		state_reg == ST_CHECK && !rd_bad && dispatch_mode == vip_pkg::DISP_HW
		|=> vvalid_reg && vaddr_reg == $past(rd_word[31:0]))
		else $error("hardware vector not presented");
	AST_PARITY_FLAG: assert property (@(posedge clock) disable iff (!rst_b)
		state_reg == ST_CHECK && rd_bad && !phantom_reg
		|=> perr_reg && pent_reg == $past(rd_entry) && !irq_reg ##2 phantom_reg)
		else $error("parity fault not reported");
	AST_LAST_CHAN_OFF: assert property (@(posedge clock) disable iff (!rst_b)
		irq_reg |-> cur_chan_reg != vip_pkg::LAST_CHAN)
		else $error("top channel dispatched");
	AST_REMAP: assert property (@(posedge clock) disable iff (!rst_b)
		map_wr_en |=> map_live_reg[$past(map_wr_chan)]
		&& map_src_reg[$past(map_wr_chan)] == $past(map_wr_src))
		else $error("channel map write lost");
	AST_ACK_RELEASE: assert property (@(posedge clock) disable iff (!rst_b)
		state_reg == ST_SHOW && cpu_ack |=> !irq_reg && state_reg == ST_IDLE
		&& !pending[$past(cur_chan_reg)])
		else $error("acknowledged channel still pending");

endmodule

// ---- vip_pkg.sv ----
// Purpose: Shared constants and helpers for the vectored interrupt prioritizer
// Assumes: 128 channels, 32-bit service routine vectors, one parity bit per entry
// Notes:   Channel numbers below are the default source-to-channel placement

// ****************************************************************
// Package
// ****************************************************************
package vip_pkg;

	// Sizes
	localparam int          NUM_CHAN    = 128;    // Request channels
	localparam int          CHAN_W      = 7;      // Channel number width
	localparam int          VEC_W       = 32;     // Vector width
	localparam int          IDX_W       = 8;      // Software index width
	localparam int          ENTRY_W     = 33;     // Vector plus parity bit
	localparam int          PAR_BIT     = 32;     // Parity position in an entry
	localparam logic [6:0]  PHANTOM_ENT = 7'h00;  // Phantom routine entry
	localparam logic [6:0]  LAST_CHAN   = 7'h7f;  // Channel with no table entry
	localparam logic [31:0] VEC_RST     = 32'h0000_0000; // Vector output at reset

	// Default channels of the named peripheral sources
	localparam int CH_ERR_HI  = 0,  CH_ERR_LO  = 20;
	localparam int CH_TICK_CMP0 = 2, CH_TICK_CMP3 = 5;
	localparam int CH_TICK_OVF0 = 6, CH_TICK_OVF1 = 7, CH_TICK_BASE = 8;
	localparam int CH_HETA_L0 = 10, CH_HETA_L1 = 24, CH_TUA_L0 = 11, CH_TUA_L1 = 25;
	localparam int CH_BSPA_L0 = 12, CH_BSPA_L1 = 26, CH_LIN_L0 = 13, CH_LIN_L1 = 27;
	localparam int CH_CVA_EVT = 14, CH_CVA_G1 = 15, CH_CVA_G2 = 28, CH_CVA_MAG = 31;
	localparam int CH_CANA_L0 = 16, CH_CANA_L1 = 29, CH_CANA_IF3 = 44;
	localparam int CH_CVB_EVT = 50, CH_CVB_G1 = 51, CH_CVB_G2 = 57, CH_CVB_MAG = 59;
	localparam int CH_CANB_L0 = 35, CH_CANB_L1 = 42, CH_CANB_IF3 = 46;
	localparam int CH_CANC_L0 = 45, CH_CANC_L1 = 55, CH_CANC_IF3 = 60;
	localparam int CH_BSPC_L0 = 37, CH_BSPC_L1 = 38, CH_BSPE_L0 = 53, CH_BSPE_L1 = 56;
	localparam int CH_PSPB_L0 = 17, CH_PSPB_L1 = 30, CH_PSPD_L0 = 49, CH_PSPD_L1 = 54;
	localparam int CH_HETB_L0 = 63, CH_HETB_L1 = 73, CH_TUB_L0 = 65, CH_TUB_L1 = 75;
	localparam int CH_ASU_L0  = 64, CH_ASU_L1  = 74, CH_I2C_L0 = 66;

	// Other sources live by default (GPIO, CRC, DMA, flash, timers and the like)
	localparam logic [127:0] OTHER_LIVE = 128'h0000ffff_ff2f0000_20008186_00e80200;

	// Dispatch styles
	typedef enum logic [1:0] {
		DISP_HW,      // Vector straight to the CPU vector port
		DISP_INDEX,   // Software reads channel index
		DISP_REGVEC   // Software reads vector register
	} vip_disp_t;

	// Even parity over one vector
	function automatic logic vec_parity(input logic [31:0] v);
		return ^v;
	endfunction

endpackage

// ---- vip_vector_ram.sv ----
// Purpose: Vector table storage, one 33-bit word per entry
// Assumes: One write port and one read port on the same clock
// Notes:   Read data come out of a register one cycle after the address

// ****************************************************************
// Vector table memory
// ****************************************************************
module vip_vector_ram (
	input  wire logic        clock,    // System clock
	input  wire logic        rst_b,    // Asynchronous reset, active low
	input  wire logic        wr_en,    // Write strobe
	input  wire logic [6:0]  wr_addr,  // Write entry
	input  wire logic [32:0] wr_data,  // Vector with parity on top
	input  wire logic [6:0]  rd_addr,  // Read entry
	output logic      [32:0] rd_data   // Registered read data
);

	// Array carries no reset: software must load it before enabling
	logic [32:0] mem [0:127];
	logic [32:0] rd_data_reg;  // Output register
	logic [32:0] rd_data_next; // Next read word

	// Next read word
	always_comb begin
		rd_data_next = mem[rd_addr];
	end

	// Array write
	always_ff @(posedge clock) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Read register
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rd_data_reg <= 33'h0_0000_0000;
		end else begin
			rd_data_reg <= rd_data_next;
		end
	end

	assign rd_data = rd_data_reg;

endmodule
